/* common/adcw_if.sv */
`timescale 1ns/100ps
interface adcw_if;
  logic req;
  logic wr;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic waitReq;
  logic ack;
  logic subClkX1Stop;
  modport dev (input req, input wr, input addr, input wdata, input subClkX1Stop,
    output rdata, output waitReq, output ack);
  modport cpu (output req, output wr, output addr, output wdata, output subClkX1Stop,
    input rdata, input waitReq, input ack);
endinterface

/* common/adcw_pkg.sv */
package adcw_pkg;
  // peripheral register offsets on the cpu bus (8-bit data)
  localparam logic [2:0] OFS_MODE = 3'h0;
  localparam logic [2:0] OFS_CHAN = 3'h1;
  localparam logic [2:0] OFS_RESULT = 3'h2;
  localparam logic [2:0] OFS_PF_MODE = 3'h3;
  localparam logic [2:0] OFS_PF_THRESH = 3'h4;
  localparam logic [2:0] OFS_STATUS = 3'h5;
  // mode register fields
  localparam int MODE_START_BIT = 7;
  localparam int MODE_TSEL_LSB = 3;
  localparam int MODE_TSEL_W = 3;
  localparam int MODE_PWR_BIT = 0;
  // channel select: low bits only
  localparam int CHAN_W = 3;
  localparam logic [7:0] CHAN_ZERO_MASK = 8'hf8;
  // power-fail mode fields
  localparam int PF_EN_BIT = 7;
  localparam int PF_SEL_BIT = 6;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] PF_MODE_RST = 8'h00;
  localparam logic [7:0] PF_THRESH_RST = 8'h00;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int STARTUP_US = 14;
  localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
  localparam int WAIT_CYC = 1;
  localparam int CONV_BASE_CYC = 16;
  // host command set
  typedef enum logic [1:0] {
    CMD_WRITE = 2'b00,
    CMD_READ = 2'b01,
    CMD_START = 2'b10
  } adcw_cmd_t;
endpackage

/* design/adcw_cpu.sv */
`timescale 1ns/100ps
import adcw_pkg::*;
module adcw_cpu #(
  parameter int StartupCyc = adcw_pkg::STARTUP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  adcw_if.cpu bus,
  input wire logic cmdValid,
  input wire adcw_pkg::adcw_cmd_t cmd,
  input wire logic [2:0] cmdAddr,
  input wire logic [7:0] cmdData,
  input wire logic onSubClkX1Stop,
  output logic cmdReady,
  output logic [7:0] rspData,
  output logic rspValid,
  output logic cmdRefused
);
  import adcw_pkg::*;

  // mode bit masks built from the shared field positions
  localparam logic [7:0] StartMask = 8'(1 << MODE_START_BIT);
  localparam logic [7:0] PwrMask = 8'(1 << MODE_PWR_BIT);

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_BUS = 2'b01,
    H_STARTUP = 2'b10
  } adcw_hst_t;

  adcw_hst_t st_r;
  logic wr_r;
  logic [2:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rsp_r;
  logic rspV_r;
  logic ref_r;
  logic [15:0] upCnt_r;
  logic forbidden;

  // accesses that need the main clock; start always writes mode, whatever the address
  assign forbidden = onSubClkX1Stop && (
    (cmd == CMD_START)
    || (cmd == CMD_WRITE && (cmdAddr == OFS_MODE || cmdAddr == OFS_CHAN
      || cmdAddr == OFS_PF_MODE || cmdAddr == OFS_PF_THRESH))
    || (cmd == CMD_READ && cmdAddr == OFS_RESULT));

  // command sequencer; start waits out the converter power-up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= H_IDLE;
      wr_r <= 1'b0;
      addr_r <= 3'h0;
      wdata_r <= 8'h00;
      rsp_r <= 8'h00;
      rspV_r <= 1'b0;
      ref_r <= 1'b0;
      upCnt_r <= 16'h0000;
    end else begin
      rspV_r <= 1'b0;
      ref_r <= 1'b0;
      unique case (st_r)
        H_IDLE: begin
          if (cmdValid && forbidden) begin
            ref_r <= 1'b1;
          end else if (cmdValid && cmd == CMD_START) begin
            // power up first, start bit only after the delay
            wr_r <= 1'b1;
            addr_r <= OFS_MODE;
            wdata_r <= (cmdData & ~StartMask) | PwrMask;
            upCnt_r <= 16'(StartupCyc);
            st_r <= H_BUS;
          end else if (cmdValid) begin
            wr_r <= (cmd == CMD_WRITE);
            addr_r <= cmdAddr;
            wdata_r <= (cmdAddr == OFS_CHAN) ? (cmdData & ~CHAN_ZERO_MASK) : cmdData;
            upCnt_r <= 16'h0000;
            st_r <= H_BUS;
          end
        end
        H_BUS: begin
          if (bus.ack) begin
            rsp_r <= bus.rdata;
            if (upCnt_r != 16'h0000) begin
              st_r <= H_STARTUP;
            end else begin
              rspV_r <= 1'b1;
              st_r <= H_IDLE;
            end
          end
        end
        H_STARTUP: begin
          if (upCnt_r == 16'h0001) begin
            wdata_r <= wdata_r | StartMask;
            upCnt_r <= 16'h0000;
            st_r <= H_BUS;
          end else begin
            upCnt_r <= upCnt_r - 16'h0001;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign bus.req = (st_r == H_BUS);
  assign bus.wr = wr_r;
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.subClkX1Stop = onSubClkX1Stop;
  assign cmdReady = (st_r == H_IDLE);
  assign rspData = rsp_r;
  assign rspValid = rspV_r;
  assign cmdRefused = ref_r;
endmodule // adcw_cpu

/* design/adcw_device.sv */
`timescale 1ns/100ps
import adcw_pkg::*;
// Functional notes
// - mode register write inserts a wait
// - no mode write on stopped main clock
// - channel select write inserts a wait
// - no channel write on stopped clock
// - channel select bits 3-7 written zero
// - mode/channel write may corrupt result
// - read result after completion, before rewrites
// - result read inserts a wait
// - no result read on stopped clock
// - power-fail mode write inserts a wait
// - threshold write inserts a wait
// - no power-fail mode write, clock stopped
// - no threshold write, clock stopped
// - at least 14 us startup before start
// - time select sets conversion length
module adcw_device #(
  parameter int WaitCyc = adcw_pkg::WAIT_CYC,
  parameter int ConvBase = adcw_pkg::CONV_BASE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  adcw_if.dev bus,
  input wire logic [7:0] sample,
  output logic [7:0] modeOut,
  output logic [2:0] chanOut,
  output logic [7:0] pfModeOut,
  output logic [7:0] pfThreshOut,
  output logic convDone,
  output logic pfFlag,
  output logic protViol
);
  import adcw_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_DONE = 2'b10
  } adcw_bst_t;

  adcw_bst_t bst_r;
  logic [7:0] waitCnt_r;
  logic [7:0] mode_r;
  logic [2:0] chan_r;
  logic [7:0] pfMode_r;
  logic [7:0] pfThresh_r;
  logic [7:0] result_r;
  logic [7:0] rdata_r;
  logic [15:0] convCnt_r;
  logic busy_r;
  logic done_r;
  logic pf_r;
  logic viol_r;
  logic waitAcc;
  logic commit;
  logic modeWr;
  logic chanWr;
  logic [15:0] convLen;
  logic [15:0] convLenWr;

  // accesses that stall the bus
  always_comb begin
    waitAcc = 1'b0;
    if (bus.req) begin
      if (bus.wr) begin
        waitAcc = (bus.addr == OFS_MODE) || (bus.addr == OFS_CHAN)
          || (bus.addr == OFS_PF_MODE) || (bus.addr == OFS_PF_THRESH);
      end else begin
        waitAcc = (bus.addr == OFS_RESULT);
      end
    end
  end

  // access sequencer; cpu holds req and address steady until ack
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bst_r <= S_IDLE;
      waitCnt_r <= 8'h00;
    end else begin
      unique case (bst_r)
        S_IDLE: begin
          if (bus.req && waitAcc) begin
            bst_r <= S_WAIT;
            waitCnt_r <= 8'(WaitCyc - 1);
          end else if (bus.req) begin
            bst_r <= S_DONE;
          end
        end
        S_WAIT: begin
          if (waitCnt_r == 8'h00) begin
            bst_r <= S_DONE;
          end else begin
            waitCnt_r <= waitCnt_r - 8'h01;
          end
        end
        S_DONE: bst_r <= S_IDLE;
        default: bst_r <= S_IDLE;
      endcase
    end
  end

  assign bus.waitReq = (bst_r == S_WAIT) || (bst_r == S_IDLE && bus.req && waitAcc);
  assign bus.ack = (bst_r == S_DONE);
  assign commit = (bst_r == S_DONE) && bus.wr;
  assign modeWr = commit && (bus.addr == OFS_MODE);
  assign chanWr = commit && (bus.addr == OFS_CHAN);

  // register writes land on the completing cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_r <= MODE_RST;
      chan_r <= CHAN_RST[CHAN_W-1:0];
      pfMode_r <= PF_MODE_RST;
      pfThresh_r <= PF_THRESH_RST;
    end else begin
      if (modeWr) begin
        mode_r <= bus.wdata;
      end
      if (chanWr) begin
        chan_r <= bus.wdata[CHAN_W-1:0];
      end
      if (commit && bus.addr == OFS_PF_MODE) begin
        pfMode_r <= bus.wdata;
      end
      if (commit && bus.addr == OFS_PF_THRESH) begin
        pfThresh_r <= bus.wdata;
      end
    end
  end

  // conversion length from the time select field
  assign convLen = 16'(ConvBase) << mode_r[MODE_TSEL_LSB +: MODE_TSEL_W];
  // a mode write brings its own select; the held copy is still the old one then
  assign convLenWr = 16'(ConvBase) << bus.wdata[MODE_TSEL_LSB +: MODE_TSEL_W];

  // conversion timer; a rewrite reloads it and clears the result to zero meanwhile
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      convCnt_r <= 16'h0000;
      result_r <= RESULT_RST;
    end else begin
      done_r <= 1'b0;
      if (modeWr || chanWr) begin
        // a channel write keeps the start bit already in the mode copy
        busy_r <= modeWr ? bus.wdata[MODE_START_BIT] : mode_r[MODE_START_BIT];
        convCnt_r <= modeWr ? convLenWr : convLen;
        result_r <= 8'h00;
      end else if (busy_r) begin
        if (convCnt_r == 16'h0000) begin
          result_r <= sample;
          done_r <= 1'b1;
          convCnt_r <= convLen;
          busy_r <= mode_r[MODE_START_BIT];
        end else begin
          convCnt_r <= convCnt_r - 16'h0001;
        end
      end
    end
  end

  // power-fail compare on each finished conversion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pf_r <= 1'b0;
    end else if (done_r && pfMode_r[PF_EN_BIT]) begin
      pf_r <= pfMode_r[PF_SEL_BIT] ? (result_r > pfThresh_r) : (result_r < pfThresh_r);
    end
  end

  // read data and forbidden-access flag; the flag only reports, hardware still answers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
      viol_r <= 1'b0;
    end else begin
      if (bst_r == S_IDLE && bus.req && !bus.wr) begin
        unique case (bus.addr)
          OFS_MODE: rdata_r <= mode_r;
          OFS_CHAN: rdata_r <= {5'h00, chan_r};
          OFS_RESULT: rdata_r <= result_r;
          OFS_PF_MODE: rdata_r <= pfMode_r;
          OFS_PF_THRESH: rdata_r <= pfThresh_r;
          OFS_STATUS: rdata_r <= {5'h00, pf_r, done_r, busy_r};
          default: rdata_r <= 8'h00;
        endcase
      end
      if (bst_r == S_IDLE && bus.req && waitAcc && bus.subClkX1Stop) begin
        viol_r <= 1'b1;
      end
    end
  end

  assign bus.rdata = rdata_r;
  assign modeOut = mode_r;
  assign chanOut = chan_r;
  assign pfModeOut = pfMode_r;
  assign pfThreshOut = pfThresh_r;
  assign convDone = done_r;
  assign pfFlag = pf_r;
  assign protViol = viol_r;
endmodule // adcw_device

/* testbench/adc_register_access_wait_tb.sv */
`timescale 1ns/100ps
module adc_register_access_wait_tb;
  import adcw_pkg::*;
  logic clk, rst_n, cmdValid, onSubClkX1Stop, cmdReady, rspValid, cmdRefused;
  logic convDone, pfFlag, protViol;
  adcw_cmd_t cmd;
  logic [2:0] cmdAddr, chanOut;
  logic [7:0] cmdData, rspData, sample, modeOut, pfModeOut, pfThreshOut;
  int err_count = 0;
  int num_checks = 0;
  adcw_if bus ();
  adcw_cpu i_adcw_cpu (.clk(clk), .rst_n(rst_n), .bus(bus),
    .cmdValid(cmdValid), .cmd(cmd), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .onSubClkX1Stop(onSubClkX1Stop), .cmdReady(cmdReady), .rspData(rspData),
    .rspValid(rspValid), .cmdRefused(cmdRefused));
  adcw_device i_adcw_device (.clk(clk), .rst_n(rst_n), .bus(bus), .sample(sample),
    .modeOut(modeOut), .chanOut(chanOut), .pfModeOut(pfModeOut), .pfThreshOut(pfThreshOut),
    .convDone(convDone), .pfFlag(pfFlag), .protViol(protViol));
  adcw_sva i_adcw_sva (.clk(clk), .rst_n(rst_n), .req(bus.req), .wr(bus.wr),
    .addr(bus.addr), .waitReq(bus.waitReq), .ack(bus.ack));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic hang();
    err_count++;
    conclude();
  endtask
  task automatic cmpVal(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one command at the falling edge; returns on response or refusal
  task automatic issue(input adcw_cmd_t c, input logic [2:0] a, input logic [7:0] d,
      output logic [7:0] rd, output logic rf);
    int n;
    cmdValid = 1'b1;
    cmd = c;
    cmdAddr = a;
    cmdData = d;
    n = 0;
    while (cmdReady !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 100) hang();
    end
    @(negedge clk);
    cmdValid = 1'b0;
    while (rspValid !== 1'b1 && cmdRefused !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 4000) hang();
    end
    rd = rspData;
    rf = cmdRefused;
    @(negedge clk);
  endtask
  // start with a time select, count cycles from response to done
  task automatic convert(input logic [2:0] sel, output int cyc);
    logic [7:0] rd;
    logic rf;
    realtime t0;
    t0 = $realtime;
    issue(CMD_START, OFS_MODE, 8'h01 | {2'h0, sel, 3'h0}, rd, rf);
    // the start sequence must span at least the power-up interval at 5 ns a cycle
    cmpVal({7'h0, ($realtime - t0) >= (STARTUP_CYC * 5.0)}, 8'h01);
    cyc = 0;
    while (convDone !== 1'b1) begin
      @(negedge clk);
      cyc++;
      if (cyc > 2000) hang();
    end
  endtask
  initial begin
    logic [7:0] rd;
    logic rf;
    int c0, c1;
    cmdValid = 1'b0;
    cmd = CMD_WRITE;
    cmdAddr = 3'h0;
    cmdData = 8'h00;
    onSubClkX1Stop = 1'b0;
    sample = 8'h5a;
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    cmpVal(modeOut, MODE_RST);
    // upper channel bits never reach the copy
    issue(CMD_WRITE, OFS_CHAN, 8'hfd, rd, rf);
    cmpVal({5'h0, chanOut}, 8'h05);
    issue(CMD_WRITE, OFS_PF_MODE, 8'hc0, rd, rf);
    cmpVal(pfModeOut, 8'hc0);
    issue(CMD_WRITE, OFS_PF_THRESH, 8'h81, rd, rf);
    cmpVal(pfThreshOut, 8'h81);
    $display("test writes done");
    // select 1 adds exactly one base length over select 0
    convert(3'h0, c0);
    issue(CMD_READ, OFS_RESULT, 8'h00, rd, rf);
    cmpVal(rd, 8'h5a);
    cmpVal({7'h0, pfFlag}, 8'h00);
    sample = 8'ha7;
    convert(3'h1, c1);
    issue(CMD_READ, OFS_RESULT, 8'h00, rd, rf);
    cmpVal(rd, 8'ha7);
    cmpVal({7'h0, pfFlag}, 8'h01);
    cmpVal(8'(c1 - c0), 8'(CONV_BASE_CYC));
    $display("test conversion done");
    // a mode rewrite spoils the held result
    issue(CMD_WRITE, OFS_MODE, 8'h08, rd, rf);
    cmpVal(modeOut, 8'h08);
    issue(CMD_READ, OFS_RESULT, 8'h00, rd, rf);
    cmpVal(rd, RESULT_RST);
    issue(CMD_READ, 3'h7, 8'h00, rd, rf);
    cmpVal(rd, 8'h00);
    issue(CMD_READ, OFS_STATUS, 8'h00, rd, rf);
    cmpVal(rd, 8'h04);
    issue(CMD_READ, OFS_CHAN, 8'h00, rd, rf);
    cmpVal(rd, 8'h05);
    $display("test rewrite done");
    // stopped main clock: stalling accesses refused, no bus cycle
    onSubClkX1Stop = 1'b1;
    issue(CMD_WRITE, OFS_MODE, 8'h10, rd, rf);
    cmpVal({7'h0, rf}, 8'h01);
    cmpVal(modeOut, 8'h08);
    issue(CMD_READ, OFS_RESULT, 8'h00, rd, rf);
    cmpVal({7'h0, rf}, 8'h01);
    cmpVal({7'h0, protViol}, 8'h00);
    issue(CMD_START, 3'h7, 8'h00, rd, rf);
    cmpVal({7'h0, rf}, 8'h01);
    onSubClkX1Stop = 1'b0;
    // clock stops after the cpu took the write: device still answers, but flags it
    cmdValid = 1'b1;
    cmd = CMD_WRITE;
    cmdAddr = OFS_PF_THRESH;
    cmdData = 8'h33;
    @(negedge clk);
    cmdValid = 1'b0;
    onSubClkX1Stop = 1'b1;
    repeat (4) @(negedge clk);
    onSubClkX1Stop = 1'b0;
    cmpVal(pfThreshOut, 8'h33);
    cmpVal({7'h0, protViol}, 8'h01);
    $display("test refusal done");
    conclude();
  end
endmodule // adc_register_access_wait_tb

/* testbench/adcw_sva.sv */
`timescale 1ns/100ps
module adcw_sva
  import adcw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic wr,
  input wire logic [2:0] addr,
  input wire logic waitReq,
  input wire logic ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // stalling accesses: wait held two cycles, then the ack
  chk_mode_wait:
    assert property ($rose(req) && wr && addr == OFS_MODE |-> waitReq[*2] ##1 (ack && !waitReq))
    else $error("mode write not stalled");
  chk_chan_wait:
    assert property ($rose(req) && wr && addr == OFS_CHAN |-> waitReq ##1 waitReq ##1 ack)
    else $error("channel write not stalled");
  chk_result_wait:
    assert property ($rose(req) && !wr && addr == OFS_RESULT |-> ##2 $rose(ack) && $past(waitReq))
    else $error("result read not stalled");
  chk_pfmode_wait:
    assert property ($rose(req) && wr && addr == OFS_PF_MODE |-> !ack[*2] ##1 ack)
    else $error("power-fail mode write not stalled");
  chk_thresh_wait:
    assert property ($rose(req) && wr && addr == OFS_PF_THRESH |-> ##2 ack && $past(waitReq, 2))
    else $error("threshold write not stalled");
  // reads above the result offset finish one cycle in, with no stall
  chk_plain_access:
    assert property ($rose(req) && !wr && addr > OFS_RESULT |-> !waitReq ##1 (ack && !waitReq))
    else $error("plain access stalled");
  chk_ack_pulse:
    assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  chk_ack_owner:
    assert property (ack |-> req && !waitReq)
    else $error("ack without request");
endmodule // adcw_sva
